// *** logic/rstc_regs.sv ***
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module rstc_regs #(
    parameter int SOFT_TICKS = rstc_pkg::SOFT_RESET_TICKS
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // slow clock cycle strobe, one pclk pulse per slow cycle
    input wire logic slow_tick,
    // external reset pin, open drain
    input wire logic nrst_in,
    output logic nrst_out,
    output logic nrst_oe,
    // brownout detector level, low while brown
    input wire logic brownout_n,
    // cause report from the reset state machine
    input wire logic cause_load,
    input wire logic [2:0] cause_code,
    // reset lines and requests
    output logic proc_reset,
    output logic periph_reset,
    output logic user_reset_req,
    output logic irq
);
    localparam int SOFT_W = $clog2(SOFT_TICKS + 1);

    // refused at elaboration, so a bad count never reaches the sequencer
    if (SOFT_TICKS < 1) begin : g_bad_soft_ticks
        $error("SOFT_TICKS must be at least one");
    end

    // bus decode
    wire logic setup = psel && !penable;
    wire logic access = psel && penable && pready;
    wire logic hit_cmd = paddr == rstc_pkg::ADDR_COMMAND;
    wire logic hit_status = paddr == rstc_pkg::ADDR_STATUS;
    wire logic hit_mode = paddr == rstc_pkg::ADDR_MODE;
    wire logic mapped = hit_cmd || hit_status || hit_mode;
    wire logic key_ok = pwdata[rstc_pkg::KEY_LSB +: 8] == rstc_pkg::WRITE_KEY;
    wire logic wr_access = access && pwrite;
    wire logic status_read = access && !pwrite && hit_status;

    // state
    rstc_pkg::rstc_mode_s mode;
    rstc_pkg::rstc_lines_s lines;
    rstc_pkg::rstc_soft_e soft_state;
    logic [SOFT_W-1:0] soft_left;
    logic [rstc_pkg::EXT_CNT_W-1:0] ext_left;
    logic [2:0] reset_cause;
    logic pin_level_sample;
    logic pin_prev;
    logic bod_prev;
    logic pin_edge_flag;
    logic brownout_flag;
    logic oe_seen;

    wire logic soft_reset_busy = soft_state == rstc_pkg::RSTC_SOFT;

    // command write decode
    // a write while busy is dropped whole, key or not
    wire logic cmd_write = wr_access && hit_cmd && key_ok && !soft_reset_busy;
    wire logic cmd_proc = pwdata[rstc_pkg::CMD_PROC];
    wire logic cmd_periph = pwdata[rstc_pkg::CMD_PERIPH];
    wire logic cmd_ext = pwdata[rstc_pkg::CMD_EXT];
    // an all-zero command starts nothing and leaves busy low
    wire logic soft_start = cmd_write && (cmd_proc || cmd_periph || cmd_ext);
    wire logic mode_write = wr_access && hit_mode && key_ok;

    // software reset sequencing
    rstc_pkg::rstc_soft_e next_soft_state;
    logic [SOFT_W-1:0] next_soft_left;
    always_comb begin
        next_soft_state = soft_state;
        next_soft_left = soft_left;
        case (soft_state)
            rstc_pkg::RSTC_IDLE: begin
                if (soft_start) begin
                    next_soft_state = rstc_pkg::RSTC_SOFT;
                    next_soft_left = SOFT_W'(SOFT_TICKS);
                end
            end
            rstc_pkg::RSTC_SOFT: begin
                if (slow_tick) begin
                    if (soft_left == SOFT_W'(1)) begin
                        next_soft_state = rstc_pkg::RSTC_IDLE;
                    end
                    next_soft_left = soft_left - SOFT_W'(1);
                end
            end
            default: begin
                next_soft_state = rstc_pkg::RSTC_IDLE;
            end
        endcase
    end

    // internal lines rise on the write, fall with the software reset
    wire logic soft_ending = soft_reset_busy && next_soft_state == rstc_pkg::RSTC_IDLE;
    rstc_pkg::rstc_lines_s next_lines;
    always_comb begin
        next_lines = lines;
        if (soft_start) begin
            next_lines.proc_reset = cmd_proc;
            next_lines.periph_reset = cmd_periph;
        end else if (soft_ending) begin
            next_lines = '0;
        end
    end

    // external pulse: 2^(L+1) slow cycles; may outlast the software reset
    // the counter width covers the longest pulse, 2^16 slow cycles
    wire logic [rstc_pkg::EXT_CNT_W-1:0] ext_load =
        rstc_pkg::EXT_CNT_W'(1) << (mode.external_pulse_length + 5'd1);
    wire logic ext_start = soft_start && cmd_ext;
    logic [rstc_pkg::EXT_CNT_W-1:0] next_ext_left;
    always_comb begin
        next_ext_left = ext_left;
        if (ext_start) begin
            next_ext_left = ext_load;
        end else if (slow_tick && ext_left != '0) begin
            next_ext_left = ext_left - rstc_pkg::EXT_CNT_W'(1);
        end
    end
    wire logic next_nrst_oe = next_ext_left != '0;

    // pin and brownout edges, set wins over the read clear
    wire logic pin_fall = pin_prev && !pin_level_sample;
    wire logic bod_fall = bod_prev && !brownout_n;
    wire logic next_pin_edge_flag = pin_fall || (pin_edge_flag && !status_read);
    wire logic next_brownout_flag = bod_fall || (brownout_flag && !status_read);

    // a low pin that this block drives itself never starts a user reset
    // the pin sample lags one cycle, so the own drive stays masked one cycle longer
    wire logic next_user_req = mode.pin_reset_enable && !pin_level_sample && !nrst_oe && !oe_seen;

    wire logic pin_irq = next_pin_edge_flag && mode.pin_edge_irq_enable && !mode.pin_reset_enable;
    wire logic bod_irq = next_brownout_flag && mode.brownout_irq_enable;
    wire logic next_irq = pin_irq || bod_irq;

    // read data
    logic [31:0] status_word;
    logic [31:0] mode_word;
    always_comb begin
        status_word = '0;
        // flag value after this edge: an event at the capture edge is reported, not lost to the clear
        status_word[rstc_pkg::ST_PIN_EDGE] = next_pin_edge_flag;
        status_word[rstc_pkg::ST_BROWNOUT] = next_brownout_flag;
        status_word[rstc_pkg::ST_CAUSE_LSB +: 3] = reset_cause;
        status_word[rstc_pkg::ST_PIN_LEVEL] = pin_level_sample;
        status_word[rstc_pkg::ST_BUSY] = soft_reset_busy;
        mode_word = '0;
        mode_word[rstc_pkg::MD_PIN_RST_EN] = mode.pin_reset_enable;
        mode_word[rstc_pkg::MD_PIN_IRQ_EN] = mode.pin_edge_irq_enable;
        mode_word[rstc_pkg::MD_LEN_LSB +: 4] = mode.external_pulse_length;
        mode_word[rstc_pkg::MD_BOD_IRQ_EN] = mode.brownout_irq_enable;
    end
    // the command register is write only and reads as zero
    wire logic [31:0] next_prdata = hit_status ? status_word :
                                    hit_mode ? mode_word : 32'h0000_0000;

    wire rstc_pkg::rstc_mode_s mode_in = '{
        brownout_irq_enable: pwdata[rstc_pkg::MD_BOD_IRQ_EN],
        external_pulse_length: pwdata[rstc_pkg::MD_LEN_LSB +: 4],
        pin_edge_irq_enable: pwdata[rstc_pkg::MD_PIN_IRQ_EN],
        pin_reset_enable: pwdata[rstc_pkg::MD_PIN_RST_EN]
    };

    // apb answer: zero wait states, data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped;
        end
    end

    // read data stands only in the access cycle, zero otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else begin
            prdata <= (setup && !pwrite) ? next_prdata : 32'h0000_0000;
        end
    end

    // only a keyed write changes the mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= '{
                brownout_irq_enable: rstc_pkg::MODE_RESET[rstc_pkg::MD_BOD_IRQ_EN],
                external_pulse_length: rstc_pkg::MODE_RESET[rstc_pkg::MD_LEN_LSB +: 4],
                pin_edge_irq_enable: rstc_pkg::MODE_RESET[rstc_pkg::MD_PIN_IRQ_EN],
                pin_reset_enable: rstc_pkg::MODE_RESET[rstc_pkg::MD_PIN_RST_EN]
            };
        end else if (mode_write) begin
            mode <= mode_in;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_state <= rstc_pkg::RSTC_IDLE;
            soft_left <= '0;
            lines <= '0;
        end else begin
            soft_state <= next_soft_state;
            soft_left <= next_soft_left;
            lines <= next_lines;
        end
    end

    // the pin is only pulled low: nrst_out stays zero and the enable does the work
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_left <= '0;
            nrst_oe <= 1'b0;
            nrst_out <= 1'b0;
        end else begin
            ext_left <= next_ext_left;
            nrst_oe <= next_nrst_oe;
            nrst_out <= 1'b0;
        end
    end

    // cause only changes on a report from the state machine, never on a read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_cause <= rstc_pkg::CAUSE_POWER_UP;
        end else if (cause_load) begin
            reset_cause <= cause_code;
        end
    end

    // pins are high when idle, so the previous levels reset high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_level_sample <= 1'b1;
            pin_prev <= 1'b1;
            bod_prev <= 1'b1;
            oe_seen <= 1'b0;
        end else begin
            pin_level_sample <= nrst_in;
            pin_prev <= pin_level_sample;
            bod_prev <= brownout_n;
            oe_seen <= nrst_oe;
        end
    end

    // set wins: an edge in the clearing cycle survives the read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_edge_flag <= 1'b0;
            brownout_flag <= 1'b0;
        end else begin
            pin_edge_flag <= next_pin_edge_flag;
            brownout_flag <= next_brownout_flag;
        end
    end

    // registered so both requests leave straight from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            user_reset_req <= 1'b0;
            irq <= 1'b0;
        end else begin
            user_reset_req <= next_user_req;
            irq <= next_irq;
        end
    end

    assign proc_reset = lines.proc_reset;
    assign periph_reset = lines.periph_reset;
endmodule
`default_nettype wire

// *** inc/rstc_pkg.sv ***
`default_nettype none
package rstc_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_COMMAND = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_MODE = 8'h08;
    // write key, top byte of command and mode writes
    localparam int KEY_LSB = 24;
    localparam logic [7:0] WRITE_KEY = 8'hA5;
    // command bits
    localparam int CMD_PROC = 0;
    localparam int CMD_PERIPH = 2;
    localparam int CMD_EXT = 3;
    // status bits
    localparam int ST_PIN_EDGE = 0;
    localparam int ST_BROWNOUT = 1;
    localparam int ST_CAUSE_LSB = 8;
    localparam int ST_PIN_LEVEL = 16;
    localparam int ST_BUSY = 17;
    // mode bits
    localparam int MD_PIN_RST_EN = 0;
    localparam int MD_PIN_IRQ_EN = 4;
    localparam int MD_LEN_LSB = 8;
    localparam int MD_BOD_IRQ_EN = 16;
    localparam logic [31:0] MODE_RESET = 32'h0000_0000;
    // reset cause codes
    localparam logic [2:0] CAUSE_POWER_UP = 3'h0;
    localparam logic [2:0] CAUSE_WATCHDOG = 3'h2;
    localparam logic [2:0] CAUSE_SOFTWARE = 3'h3;
    localparam logic [2:0] CAUSE_PIN = 3'h4;
    localparam logic [2:0] CAUSE_BROWNOUT = 3'h5;
    // software reset length in slow clock cycles
    localparam int SOFT_RESET_TICKS = 3;
    localparam int EXT_CNT_W = 17;

    typedef struct packed {
        logic brownout_irq_enable;
        logic [3:0] external_pulse_length;
        logic pin_edge_irq_enable;
        logic pin_reset_enable;
    } rstc_mode_s;

    typedef struct packed {
        logic proc_reset;
        logic periph_reset;
    } rstc_lines_s;

    typedef enum logic [1:0] {
        RSTC_IDLE = 2'b00,
        RSTC_SOFT = 2'b01
    } rstc_soft_e;
endpackage
`default_nettype wire

// *** verif/rstc_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
module rstc_sva #(
    parameter int SOFT_TICKS = 3
) (
    // apb
    input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    // pins and lines
    input wire logic slow_tick, nrst_in, nrst_out, nrst_oe, brownout_n, cause_load,
    input wire logic [2:0] cause_code,
    input wire logic proc_reset, periph_reset, user_reset_req, irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable && pready;
    wire keyed = acc && pwrite && pwdata[31:24] == rstc_pkg::WRITE_KEY;
    wire cmd_ok = keyed && paddr == rstc_pkg::ADDR_COMMAND;
    wire st_rd = acc && !pwrite && paddr == rstc_pkg::ADDR_STATUS;
    wire quiet = brownout_n && nrst_in;
    logic [16:0] md;
    logic [2:0] cause_q;
    logic [16:0] ext_cnt;
    logic [3:0] soft_cnt;
    // mirror of mode and cause, so lengths and enables can be judged at the ports
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            md <= '0;
            cause_q <= '0;
            ext_cnt <= '0;
            soft_cnt <= '0;
        end else begin
            if (keyed && paddr == rstc_pkg::ADDR_MODE) md <= pwdata[16:0];
            if (cause_load) cause_q <= cause_code;
            ext_cnt <= nrst_oe ? ext_cnt + 17'(slow_tick) : '0;
            soft_cnt <= periph_reset ? soft_cnt + 4'(slow_tick) : '0;
        end
    end
    chk_key_periph: assert property ($rose(periph_reset) |-> $past(cmd_ok && pwdata[2]))
        else $error("peripheral reset without keyed command");
    chk_key_pin: assert property ($rose(nrst_oe) |-> $past(cmd_ok && pwdata[3]) && !nrst_out)
        else $error("pin driven without keyed command");
    chk_busy_ignore: assert property (cmd_ok && periph_reset |=> !$rose(nrst_oe) && !$rose(proc_reset))
        else $error("command taken while busy");
    chk_soft_len: assert property ($fell(periph_reset) |-> soft_cnt == SOFT_TICKS)
        else $error("software reset length wrong");
    chk_pulse_len: assert property ($fell(nrst_oe) |-> ext_cnt == (17'd2 << md[11:8]))
        else $error("external pulse length wrong");
    chk_irq_cause: assert property ($rose(irq) |-> md[16] || (md[4] && !md[0]))
        else $error("interrupt from disabled source");
    chk_irq_clear: assert property (st_rd && quiet && $past(quiet) && $past(quiet, 2) |-> ##1 !irq)
        else $error("interrupt kept after status read");
    chk_cause_keep: assert property (st_rd |-> prdata[10:8] == cause_q)
        else $error("reset cause field wrong");
    chk_level_seen: assert property (st_rd && nrst_in == $past(nrst_in) && nrst_in == $past(nrst_in, 2)
        |-> prdata[16] == nrst_in)
        else $error("pin level bit wrong");
    chk_user_req: assert property ($rose(user_reset_req) |-> md[0])
        else $error("user reset while disabled");
    chk_user_self: assert property ($past(nrst_oe) || $past(nrst_oe, 2) |-> !user_reset_req)
        else $error("user reset from own pin drive");
    chk_busy_bit: assert property (st_rd && $past(periph_reset) |-> prdata[17])
        else $error("busy bit low during software reset");
    cover property (cmd_ok);
    cover property ($rose(irq));
    cover property ($fell(nrst_oe));
endmodule
`default_nettype wire

// *** verif/rstc_far_side.sv ***
`timescale 1ns/1ns
`default_nettype none
module rstc_far_side (
    // clock and pin drivers
    input wire logic pclk, presetn, nrst_out, nrst_oe, ext_low,
    // slow clock strobe and pin level
    output logic slow_tick,
    output logic nrst_in
);
    logic [2:0] div;
    // pin has a pull-up: high unless the block or a button pulls it down
    assign nrst_in = !((nrst_oe && !nrst_out) || ext_low);
    // slow clock runs free, one strobe every five master cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div <= '0;
            slow_tick <= 1'b0;
        end else begin
            div <= (div == 3'd4) ? 3'd0 : div + 3'd1;
            slow_tick <= (div == 3'd3);
        end
    end
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, brownout_n, cause_load, ext_low, err, sp;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] cause_code;
    logic [1:0] p1;
    logic pready, pslverr, slow_tick, nrst_in, nrst_out, nrst_oe, proc_reset, periph_reset, user_reset_req, irq;
    int fails, num_checks, cyc, nb, ne;
    localparam logic [31:0] KEY = {rstc_pkg::WRITE_KEY, 24'h00_0000};
    logic [2:0] codes [5] = '{rstc_pkg::CAUSE_POWER_UP, rstc_pkg::CAUSE_WATCHDOG,
        rstc_pkg::CAUSE_SOFTWARE, rstc_pkg::CAUSE_PIN, rstc_pkg::CAUSE_BROWNOUT};
    rstc_regs #(.SOFT_TICKS(rstc_pkg::SOFT_RESET_TICKS)) i_rstc_regs (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .slow_tick(slow_tick), .nrst_in(nrst_in), .nrst_out(nrst_out),
        .nrst_oe(nrst_oe), .brownout_n(brownout_n), .cause_load(cause_load), .cause_code(cause_code),
        .proc_reset(proc_reset), .periph_reset(periph_reset), .user_reset_req(user_reset_req), .irq(irq));
    rstc_far_side i_rstc_far_side (.pclk(pclk), .presetn(presetn), .nrst_out(nrst_out), .nrst_oe(nrst_oe),
        .ext_low(ext_low), .slow_tick(slow_tick), .nrst_in(nrst_in));
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        if (fails == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // idle edge first, so back-to-back calls never assign psel twice in one step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    endtask
    task automatic count_ticks();
        int n;
        n = 0;
        nb = 0;
        ne = 0;
        sp = 1'b0;
        do begin
            @(posedge pclk);
            if (n == 0) p1 = {periph_reset, nrst_oe};
            if (slow_tick && periph_reset) nb++;
            if (slow_tick && nrst_oe) ne++;
            if (proc_reset) sp = 1'b1;
            n++;
        end while ((periph_reset || nrst_oe) && n < 500);
    endtask
    initial begin
        {psel, penable, pwrite, cause_load, ext_low, presetn} = '0;
        {paddr, pwdata, cause_code} = '0;
        brownout_n = 1'b1;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rdc(rstc_pkg::ADDR_MODE, rstc_pkg::MODE_RESET);
        rdc(rstc_pkg::ADDR_STATUS, 32'h0001_0000);
        apb(1'b0, 8'h0C, 32'h0000_0000);
        chk(32'(err), 32'h0000_0001);
        apb(1'b1, rstc_pkg::ADDR_MODE, 32'h1201_0111);
        rdc(rstc_pkg::ADDR_MODE, 32'h0000_0000);
        apb(1'b1, rstc_pkg::ADDR_MODE, KEY | 32'h0001_0110);
        apb(1'b1, rstc_pkg::ADDR_COMMAND, 32'h5A00_000C);
        @(negedge pclk);
        chk(32'({periph_reset, nrst_oe}), 32'h0000_0000);
        apb(1'b1, rstc_pkg::ADDR_COMMAND, KEY | 32'h0000_000C);
        fork
            count_ticks();
            begin
                // let the own pin edge land first, so the read reports it
                repeat (3) @(posedge pclk);
                rdc(rstc_pkg::ADDR_STATUS, 32'h0002_0001);
                apb(1'b1, rstc_pkg::ADDR_COMMAND, KEY | 32'h0000_0001);
            end
        join
        chk(32'(p1), 32'h0000_0003);
        chk(nb, rstc_pkg::SOFT_RESET_TICKS);
        chk(ne, 32'h0000_0004);
        chk(32'(sp), 32'h0000_0000);
        // the busy read cleared the flag, so press the button for a fresh edge
        ext_low <= 1'b1;
        repeat (3) @(posedge pclk);
        ext_low <= 1'b0;
        repeat (2) @(negedge pclk);
        chk(32'(irq), 32'h0000_0001);
        rdc(rstc_pkg::ADDR_STATUS, 32'h0001_0001);
        repeat (2) @(negedge pclk);
        chk(32'(irq), 32'h0000_0000);
        @(posedge pclk);
        brownout_n <= 1'b0;
        repeat (4) @(negedge pclk);
        chk(32'(irq), 32'h0000_0001);
        rdc(rstc_pkg::ADDR_STATUS, 32'h0001_0002);
        brownout_n <= 1'b1;
        repeat (2) @(negedge pclk);
        chk(32'(irq), 32'h0000_0000);
        apb(1'b1, rstc_pkg::ADDR_MODE, KEY | 32'h0000_0111);
        @(posedge pclk);
        brownout_n <= 1'b0;
        ext_low <= 1'b1;
        repeat (4) @(negedge pclk);
        chk(32'({irq, user_reset_req}), 32'h0000_0001);
        @(posedge pclk);
        brownout_n <= 1'b1;
        ext_low <= 1'b0;
        rdc(rstc_pkg::ADDR_STATUS, 32'h0001_0003);
        foreach (codes[i]) begin
            @(posedge pclk);
            cause_load <= 1'b1;
            cause_code <= codes[i];
            @(posedge pclk);
            cause_load <= 1'b0;
            repeat (2) rdc(rstc_pkg::ADDR_STATUS, 32'h0001_0000 | {21'h00_0000, codes[i], 8'h00});
        end
        // own pulse with user reset enabled: shortest length, no user reset
        apb(1'b1, rstc_pkg::ADDR_MODE, KEY | 32'h0000_0001);
        apb(1'b1, rstc_pkg::ADDR_COMMAND, KEY | 32'h0000_0009);
        count_ticks();
        chk(32'(sp), 32'h0000_0001);
        chk(ne, 32'h0000_0002);
        @(negedge pclk);
        chk(32'(user_reset_req), 32'h0000_0000);
        give_verdict();
    end
endmodule
bind rstc_regs rstc_sva #(.SOFT_TICKS(SOFT_TICKS)) i_rstc_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .slow_tick(slow_tick), .nrst_in(nrst_in), .nrst_out(nrst_out), .nrst_oe(nrst_oe),
    .brownout_n(brownout_n), .cause_load(cause_load), .cause_code(cause_code), .proc_reset(proc_reset),
    .periph_reset(periph_reset), .user_reset_req(user_reset_req), .irq(irq));
`default_nettype wire
